//--- shared/cmp_pkg.sv
// Package for the configuration mode and power-down block.
// Assumes a 50 MHz system clock; shared by the design and its bench.
package cmp_pkg;

  // --------------------
  // Timing
  // --------------------
  localparam int REF_CLK_MHZ = 50;
  localparam int OUT_DELAY_NS = 10;
  localparam int OUT_DELAY_RAW = (OUT_DELAY_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int OUT_DELAY_CYC = (OUT_DELAY_RAW < 1) ? 1 : OUT_DELAY_RAW;
  localparam int MCLK_KHZ = 1000;
  localparam int MCLK_HALF_CYC = (REF_CLK_MHZ * 1000) / (2 * MCLK_KHZ);
  localparam int UNIT_BITS = 8;

  // --------------------
  // Register map
  // --------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LENGTH = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0C;
  localparam int CTRL_SINGLE_PIN = 0;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_CFG_LSB = 2;
  localparam int ST_PD_LSB = 5;
  localparam int ST_INIT_VALID = 7;
  localparam int ST_INIT_PIN = 8;
  localparam int ST_DONE_PIN = 9;
  localparam int ST_W = 10;
  localparam logic [15:0] LENGTH_RST = 16'h0010;

  // --------------------
  // Types
  // --------------------
  typedef enum logic [1:0] {
    MODE_SLAVE = 2'b00,
    MODE_MASTER = 2'b01,
    MODE_EXPRESS = 2'b10
  } cmp_mode_e;

  typedef enum logic [2:0] {
    CF_CLEAR = 3'b000,
    CF_SAMPLE = 3'b001,
    CF_LOAD = 3'b010,
    CF_USER = 3'b011,
    CF_HOLD = 3'b100
  } cmp_cfg_e;

  typedef enum logic [1:0] {
    PD_RUN = 2'b00,
    PD_IN_OFF = 2'b01,
    PD_ALL_OFF = 2'b10,
    PD_WAKE = 2'b11
  } cmp_pd_e;

  typedef struct packed {
    logic input_en;
    logic output_en;
    logic global_set_reset;
    logic global_output_float;
    logic pullup_en;
    logic mode_pullup_en;
    logic tap_en;
  } cmp_buf_ctl_s;

  typedef struct packed {
    logic config_clock_o;
    logic config_clock_oe_n;
    logic init_o;
    logic init_oe_n;
    logic done_o;
    logic done_oe_n;
    logic high_while_loading_o;
    logic high_while_loading_oe_n;
    logic low_while_loading_o;
    logic low_while_loading_oe_n;
  } cmp_pin_out_s;

  localparam cmp_buf_ctl_s BUF_RST = 7'b0011000;
  localparam cmp_pin_out_s PIN_RST = 10'b0101010101;

  // Single-pin parts read only the low mode pin
  function automatic cmp_mode_e decode_mode(input logic single_pin, input logic hi, input logic lo);
    cmp_mode_e m;
    if (single_pin) begin
      m = lo ? MODE_SLAVE : MODE_MASTER;
    end else if (!hi) begin
      m = MODE_EXPRESS;
    end else begin
      m = lo ? MODE_SLAVE : MODE_MASTER;
    end
    return m;
  endfunction

endpackage

//--- design/cmp_top.sv
// Configuration mode selection and power-down sequencing, APB slave.
// Assumes board pins are asynchronous to ref_clk and that link_clk is
// the configuration clock pin as seen from outside; it may stop, but it
// must give a few edges under reset and two after it before any frame.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
module cmp_top #(
  parameter int LEN_W = 16,
  parameter int OUT_DELAY = cmp_pkg::OUT_DELAY_CYC,
  parameter int MCLK_HALF = cmp_pkg::MCLK_HALF_CYC
) (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic link_clk,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Board pins, inputs
  input wire logic power_down_n,
  input wire logic program_n,
  input wire logic load_style_select_hi,
  input wire logic load_style_select_lo,
  input wire logic chain_select,
  input wire logic init_i,
  input wire logic done_i,
  // Board pins, drivers and buffer controls
  output cmp_pkg::cmp_pin_out_s pin_out,
  output cmp_pkg::cmp_buf_ctl_s buf_ctl,
  output cmp_pkg::cmp_mode_e load_style
);

  localparam int TIM_W = $clog2(OUT_DELAY + 1);
  localparam int DIV_W = $clog2(MCLK_HALF + 1);
  localparam int BIT_W = $clog2(cmp_pkg::UNIT_BITS);
  localparam int SYNC_W = 6;
  localparam logic [SYNC_W-1:0] SYNC_RST = 6'h3C;

  // --------------------
  // Pin synchronisers
  // --------------------
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic pd_n_s;
  logic prog_n_s;
  logic mhi_s;
  logic mlo_s;
  logic init_s;
  logic done_s;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
    end else begin
      sync1 <= {power_down_n, program_n, load_style_select_hi, load_style_select_lo, init_i, done_i};
      sync2 <= sync1;
    end
  end

  always_comb begin
    pd_n_s = sync2[5];
    prog_n_s = sync2[4]; // Never gated by power-down
    mhi_s = sync2[3] & buf_ctl.input_en;
    mlo_s = sync2[2] & buf_ctl.input_en;
    init_s = sync2[1] & buf_ctl.input_en;
    done_s = sync2[0] & buf_ctl.input_en;
  end

  // --------------------
  // Power-down sequencer
  // --------------------
  cmp_pkg::cmp_pd_e pd_state;
  cmp_pkg::cmp_pd_e next_pd_state;
  logic [TIM_W-1:0] pd_timer;
  logic [TIM_W-1:0] next_pd_timer;
  logic pd_act;

  // A short pulse still runs the full sequence, so outputs never glitch
  always_comb begin
    next_pd_state = pd_state;
    next_pd_timer = pd_timer;
    case (pd_state)
      cmp_pkg::PD_RUN: begin
        if (!pd_n_s) begin
          next_pd_state = cmp_pkg::PD_IN_OFF;
          next_pd_timer = TIM_W'(OUT_DELAY - 1);
        end
      end
      cmp_pkg::PD_IN_OFF: begin
        if (pd_timer == '0) begin
          next_pd_state = cmp_pkg::PD_ALL_OFF;
        end else begin
          next_pd_timer = pd_timer - TIM_W'(1);
        end
      end
      cmp_pkg::PD_ALL_OFF: begin
        if (pd_n_s) begin
          next_pd_state = cmp_pkg::PD_WAKE;
          next_pd_timer = TIM_W'(OUT_DELAY - 1);
        end
      end
      cmp_pkg::PD_WAKE: begin
        if (pd_timer == '0) begin
          next_pd_state = cmp_pkg::PD_RUN;
        end else begin
          next_pd_timer = pd_timer - TIM_W'(1);
        end
      end
      default: begin
        next_pd_state = cmp_pkg::PD_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pd_state <= cmp_pkg::PD_RUN;
      pd_timer <= '0;
    end else begin
      pd_state <= next_pd_state;
      pd_timer <= next_pd_timer;
    end
  end

  assign pd_act = (pd_state != cmp_pkg::PD_RUN);

  // --------------------
  // Configuration control
  // --------------------
  cmp_pkg::cmp_cfg_e cfg;
  cmp_pkg::cmp_cfg_e next_cfg;
  cmp_pkg::cmp_mode_e next_load_style;
  logic pd_in_cfg;
  logic next_pd_in_cfg;
  logic ctrl_single;
  logic [LEN_W-1:0] length;
  logic [LEN_W-1:0] unit_cnt;
  logic load_done;

  assign load_done = (unit_cnt >= length);

  always_comb begin
    next_cfg = cfg;
    next_load_style = load_style;
    next_pd_in_cfg = pd_in_cfg;
    if (!prog_n_s) begin
      next_cfg = cmp_pkg::CF_CLEAR;
    end else begin
      case (cfg)
        cmp_pkg::CF_CLEAR: begin
          if (!pd_act) begin
            next_cfg = cmp_pkg::CF_SAMPLE;
          end
        end
        cmp_pkg::CF_SAMPLE: begin
          if (pd_act) begin
            next_cfg = cmp_pkg::CF_HOLD;
          end else begin
            next_load_style = cmp_pkg::decode_mode(ctrl_single, mhi_s, mlo_s);
            next_cfg = cmp_pkg::CF_LOAD;
          end
        end
        cmp_pkg::CF_LOAD: begin
          if (pd_act) begin
            next_cfg = cmp_pkg::CF_HOLD;
          end else if (load_done) begin
            next_cfg = cmp_pkg::CF_USER;
          end
        end
        cmp_pkg::CF_USER: begin
          // Mode pins no longer looked at; power-down keeps the loaded state
          next_cfg = cmp_pkg::CF_USER;
        end
        cmp_pkg::CF_HOLD: begin
          if (!pd_act) begin
            next_cfg = cmp_pkg::CF_CLEAR;
          end
        end
        default: begin
          next_cfg = cmp_pkg::CF_CLEAR;
        end
      endcase
    end
    if (next_cfg == cmp_pkg::CF_USER && cfg != cmp_pkg::CF_USER) begin
      next_pd_in_cfg = 1'b0;
    end
    if (pd_act && cfg != cmp_pkg::CF_USER) begin
      next_pd_in_cfg = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg <= cmp_pkg::CF_CLEAR;
      load_style <= cmp_pkg::MODE_SLAVE;
      pd_in_cfg <= 1'b0;
    end else begin
      cfg <= next_cfg;
      load_style <= next_load_style;
      pd_in_cfg <= next_pd_in_cfg;
    end
  end

  // --------------------
  // Unit counting
  // --------------------
  logic [BIT_W-1:0] bit_cnt;
  logic [BIT_W-1:0] next_bit_cnt;
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic [LEN_W-1:0] next_unit_cnt;
  logic mclk;
  logic next_mclk;
  // At most two link edges fall in one ref_clk cycle, so short gray counts do
  localparam int GRAY_W = 4;
  logic [GRAY_W-1:0] edge_gray;
  logic [GRAY_W-1:0] sel_gray;
  logic [2*GRAY_W-1:0] gray_s1;
  logic [2*GRAY_W-1:0] gray_s2;
  wire logic [2*GRAY_W-1:0] count_bin;
  logic [2*GRAY_W-1:0] count_prev;
  logic [GRAY_W-1:0] edge_step;
  logic [GRAY_W-1:0] sel_step;
  logic [GRAY_W:0] bit_sum;

  // Gray to binary for both link counts, one bit per pass
  for (genvar i = 0; i < GRAY_W; i++) begin : g_gray
    assign count_bin[GRAY_W+i] = ^gray_s2[2*GRAY_W-1:GRAY_W+i];
    assign count_bin[i] = ^gray_s2[GRAY_W-1:i];
  end

  // Link edges seen since the last cycle; outside loading they are dropped
  assign edge_step = count_bin[2*GRAY_W-1:GRAY_W] - count_prev[2*GRAY_W-1:GRAY_W];
  assign sel_step = count_bin[GRAY_W-1:0] - count_prev[GRAY_W-1:0];

  always_comb begin
    next_unit_cnt = unit_cnt;
    next_bit_cnt = bit_cnt;
    next_div_cnt = div_cnt;
    next_mclk = mclk;
    bit_sum = (GRAY_W+1)'(bit_cnt) + (GRAY_W+1)'(edge_step);
    if (cfg != cmp_pkg::CF_LOAD) begin
      next_div_cnt = '0;
      next_mclk = 1'b0;
      if (cfg == cmp_pkg::CF_CLEAR) begin
        next_unit_cnt = '0;
        next_bit_cnt = '0;
      end
    end else if (load_style == cmp_pkg::MODE_MASTER) begin
      // Clock made here by division; a bit is counted per rising edge
      if (div_cnt == DIV_W'(MCLK_HALF - 1)) begin
        next_div_cnt = '0;
        next_mclk = !mclk;
        if (!mclk) begin
          if (bit_cnt == BIT_W'(cmp_pkg::UNIT_BITS - 1)) begin
            next_bit_cnt = '0;
            next_unit_cnt = unit_cnt + LEN_W'(1);
          end else begin
            next_bit_cnt = bit_cnt + BIT_W'(1);
          end
        end
      end else begin
        next_div_cnt = div_cnt + DIV_W'(1);
      end
    end else if (load_style == cmp_pkg::MODE_EXPRESS) begin
      next_unit_cnt = unit_cnt + LEN_W'(sel_step);
    end else begin
      // Serial: whole units out of the bits gathered so far
      next_unit_cnt = unit_cnt + LEN_W'(bit_sum / cmp_pkg::UNIT_BITS);
      next_bit_cnt = BIT_W'(bit_sum % cmp_pkg::UNIT_BITS);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      unit_cnt <= '0;
      bit_cnt <= '0;
      div_cnt <= '0;
      mclk <= 1'b0;
      gray_s1 <= '0;
      gray_s2 <= '0;
      count_prev <= '0;
    end else begin
      unit_cnt <= next_unit_cnt;
      bit_cnt <= next_bit_cnt;
      div_cnt <= next_div_cnt;
      mclk <= next_mclk;
      gray_s1 <= {edge_gray, sel_gray};
      gray_s2 <= gray_s1;
      count_prev <= count_bin;
    end
  end

  // --------------------
  // Link clock domain
  // --------------------
  logic lsync1;
  logic lsync2;
  logic [GRAY_W-1:0] edge_cnt;
  logic [GRAY_W-1:0] next_edge_cnt;
  logic [GRAY_W-1:0] sel_cnt;
  logic [GRAY_W-1:0] next_sel_cnt;
  logic [GRAY_W-1:0] next_edge_gray;
  logic [GRAY_W-1:0] next_sel_gray;

  // Counts run free and carry no load state, so a clock that stops between
  // frames never leaves stale mode or gating behind; the system side decides
  always_comb begin
    next_edge_cnt = edge_cnt + GRAY_W'(1);
    next_sel_cnt = sel_cnt;
    if (chain_select) begin
      next_sel_cnt = sel_cnt + GRAY_W'(1);
    end
    next_edge_gray = next_edge_cnt ^ (next_edge_cnt >> 1);
    next_sel_gray = next_sel_cnt ^ (next_sel_cnt >> 1);
  end

  always_ff @(posedge link_clk) begin
    lsync1 <= rst;
    lsync2 <= lsync1;
    if (lsync2) begin
      edge_cnt <= '0;
      sel_cnt <= '0;
      edge_gray <= '0;
      sel_gray <= '0;
    end else begin
      edge_cnt <= next_edge_cnt;
      sel_cnt <= next_sel_cnt;
      edge_gray <= next_edge_gray;
      sel_gray <= next_sel_gray;
    end
  end

  // --------------------
  // Buffer and pin drivers
  // --------------------
  cmp_pkg::cmp_buf_ctl_s next_buf_ctl;
  cmp_pkg::cmp_pin_out_s next_pin_out;
  logic in_en;
  logic out_en;
  logic cfg_busy;
  logic master_load;

  always_comb begin
    in_en = (pd_state == cmp_pkg::PD_RUN) || (pd_state == cmp_pkg::PD_WAKE);
    // Outputs stay on through the inputs-off step, so they drop after the inputs
    out_en = (pd_state == cmp_pkg::PD_RUN) || (pd_state == cmp_pkg::PD_IN_OFF);
    cfg_busy = (cfg != cmp_pkg::CF_USER);
    master_load = (cfg == cmp_pkg::CF_LOAD) && (load_style == cmp_pkg::MODE_MASTER);
    next_buf_ctl.input_en = in_en;
    next_buf_ctl.output_en = out_en;
    next_buf_ctl.global_output_float = !out_en;
    next_buf_ctl.global_set_reset = (pd_state == cmp_pkg::PD_IN_OFF) || (pd_state == cmp_pkg::PD_ALL_OFF);
    next_buf_ctl.pullup_en = in_en;
    next_buf_ctl.mode_pullup_en = in_en && cfg_busy;
    next_buf_ctl.tap_en = (pd_state == cmp_pkg::PD_RUN);
    next_pin_out = cmp_pkg::PIN_RST;
    if (out_en) begin
      next_pin_out.config_clock_o = mclk;
      next_pin_out.config_clock_oe_n = !master_load;
      next_pin_out.init_oe_n = !((cfg == cmp_pkg::CF_CLEAR) || (cfg == cmp_pkg::CF_SAMPLE));
      next_pin_out.done_oe_n = !cfg_busy;
      next_pin_out.high_while_loading_o = 1'b1;
      next_pin_out.high_while_loading_oe_n = !cfg_busy;
      next_pin_out.low_while_loading_oe_n = !cfg_busy;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      buf_ctl <= cmp_pkg::BUF_RST;
      pin_out <= cmp_pkg::PIN_RST;
    end else begin
      buf_ctl <= next_buf_ctl;
      pin_out <= next_pin_out;
    end
  end

  // --------------------
  // APB registers
  // --------------------
  logic next_ctrl_single;
  logic [LEN_W-1:0] next_length;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [cmp_pkg::ST_W-1:0] status;

  always_comb begin
    status = '0;
    status[cmp_pkg::ST_MODE_LSB +: 2] = load_style;
    status[cmp_pkg::ST_CFG_LSB +: 3] = cfg;
    status[cmp_pkg::ST_PD_LSB +: 2] = pd_state;
    status[cmp_pkg::ST_INIT_VALID] = !pd_in_cfg;
    status[cmp_pkg::ST_INIT_PIN] = init_s;
    status[cmp_pkg::ST_DONE_PIN] = done_s;
    next_ctrl_single = ctrl_single;
    next_length = length;
    next_prdata = '0;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      next_pready = 1'b1;
      case (paddr)
        cmp_pkg::ADDR_CTRL: next_prdata = 32'(ctrl_single);
        cmp_pkg::ADDR_LENGTH: next_prdata = 32'(length);
        cmp_pkg::ADDR_STATUS: next_prdata = 32'(status);
        cmp_pkg::ADDR_COUNT: next_prdata = 32'(unit_cnt);
        default: next_pslverr = 1'b1;
      endcase
    end
    // Writes land at the access edge, when the master sees pready
    if (psel && penable && pready && pwrite) begin
      if (paddr == cmp_pkg::ADDR_CTRL) begin
        next_ctrl_single = pwdata[cmp_pkg::CTRL_SINGLE_PIN];
      end
      if (paddr == cmp_pkg::ADDR_LENGTH) begin
        next_length = pwdata[LEN_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_single <= 1'b0;
      length <= LEN_W'(cmp_pkg::LENGTH_RST);
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl_single <= next_ctrl_single;
      length <= next_length;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

endmodule

//--- tb/cmp_checker.sv
// Port assertions for the mode and power-down block.
// Assumes one ref_clk domain with synchronous active-high rst.
module cmp_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Watched ports
  input wire logic power_down_n,
  input wire cmp_pkg::cmp_pin_out_s pin_out,
  input wire cmp_pkg::cmp_buf_ctl_s buf_ctl,
  input wire cmp_pkg::cmp_mode_e load_style
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // --------------------
  // Power-down sequence
  // --------------------
  gsr_with_inputs_a: assert property (buf_ctl.input_en != buf_ctl.global_set_reset)
    else $error("set/reset not paired with input enable");
  float_with_out_a: assert property (buf_ctl.output_en != buf_ctl.global_output_float)
    else $error("float not paired with output enable");
  pullups_off_a: assert property (!buf_ctl.input_en |-> !buf_ctl.pullup_en && !buf_ctl.mode_pullup_en)
    else $error("pull-up left on with inputs off");
  entry_order_a: assert property ($fell(buf_ctl.input_en) |-> buf_ctl.output_en ##1 !buf_ctl.output_en)
    else $error("outputs not disabled one cycle after inputs");
  exit_order_a: assert property ($rose(buf_ctl.input_en) && !buf_ctl.output_en |=> buf_ctl.output_en)
    else $error("outputs not enabled one cycle after inputs");
  entry_delay_a: assert property ($fell(power_down_n) |-> ##[1:6] !buf_ctl.input_en)
    else $error("power-down not seen in time");
  pins_off_a: assert property (!buf_ctl.output_en |-> &{pin_out.config_clock_oe_n, pin_out.init_oe_n,
    pin_out.done_oe_n, pin_out.high_while_loading_oe_n, pin_out.low_while_loading_oe_n})
    else $error("pin driven with outputs off");
  tap_off_a: assert property (!buf_ctl.output_en |-> !buf_ctl.tap_en)
    else $error("test port usable in power-down");
  // --------------------
  // Configuration pins
  // --------------------
  open_drain_a: assert property (!pin_out.init_oe_n |-> !pin_out.init_o)
    else $error("init pin driven high");
  clock_master_a: assert property (!pin_out.config_clock_oe_n |-> load_style == cmp_pkg::MODE_MASTER)
    else $error("clock driven outside master mode");
  load_levels_a: assert property (!pin_out.high_while_loading_oe_n |-> pin_out.high_while_loading_o &&
    !pin_out.low_while_loading_oe_n && !pin_out.low_while_loading_o)
    else $error("loading level pins wrong");
endmodule

bind cmp_top cmp_checker cmp_checker_inst (.ref_clk(ref_clk), .rst(rst), .power_down_n(power_down_n),
  .pin_out(pin_out), .buf_ctl(buf_ctl), .load_style(load_style));

//--- tb/cmp_partner.sv
// Model of the configuration source and the board pull-ups.
// Assumes the bench calls send() to hand over units on the link clock.
module cmp_partner (
  // Towards the device
  output logic link_clk,
  output logic chain_select,
  output logic init_i,
  output logic done_i,
  // From the device
  input wire cmp_pkg::cmp_pin_out_s pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    link_clk = 1'b0;
    chain_select = 1'b0;
    // Link side resets through a synchroniser, so it needs edges under reset
    repeat (4) begin
      #6 link_clk = 1'b1;
      #6 link_clk = 1'b0;
    end
  end
  // Board pull-ups read high when the open-drain pins are released
  assign init_i = pin_out.init_oe_n ? 1'b1 : pin_out.init_o;
  assign done_i = pin_out.done_oe_n ? 1'b1 : pin_out.done_o;
  // Clock stands low between frames so no stray edge is counted
  task automatic send(input int n, input logic cs);
    chain_select = cs;
    #3;
    repeat (n) begin
      #6 link_clk = 1'b1;
      #6 link_clk = 1'b0;
    end
  endtask
endmodule

//--- tb/test_cmp_top.sv
// Self-checking bench for the mode and power-down block.
// Assumes the checker is bound in and the partner drives the link.
module test_cmp_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, psel, penable, pwrite, pd_n, prog_n, m_hi, m_lo, err;
  logic pready, pslverr, link_clk, chain_select, init_i, done_i;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  cmp_pkg::cmp_pin_out_s pin_out;
  cmp_pkg::cmp_buf_ctl_s buf_ctl;
  cmp_pkg::cmp_mode_e load_style;
  int miscompares = 0;
  int checks_done = 0;
  int seed = 32'h1390;
  int len;
  cmp_top #(.MCLK_HALF(2)) cmp_top_inst (.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_down_n(pd_n), .program_n(prog_n), .load_style_select_hi(m_hi),
    .load_style_select_lo(m_lo), .chain_select(chain_select), .init_i(init_i), .done_i(done_i),
    .pin_out(pin_out), .buf_ctl(buf_ctl), .load_style(load_style));
  cmp_partner cmp_partner_inst (.link_clk(link_clk), .chain_select(chain_select), .init_i(init_i),
    .done_i(done_i), .pin_out(pin_out));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // --------------------
  // Helpers
  // --------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  function automatic cmp_pkg::cmp_mode_e exp_mode(input logic [2:0] c);
    if (c[0] | c[2]) begin
      return c[1] ? cmp_pkg::MODE_SLAVE : cmp_pkg::MODE_MASTER;
    end
    return cmp_pkg::MODE_EXPRESS;
  endfunction
  // One idle edge first, so back-to-back calls never drive psel twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      summarize();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_cfg(input logic [2:0] s);
    int n;
    n = 0;
    do begin
      apb(1'b0, cmp_pkg::ADDR_STATUS, 32'h0);
      n++;
    end while (q[4:2] !== s && n < 300);
    if (n >= 300) begin
      miscompares++;
      summarize();
    end
  endtask
  task automatic pd();
    pd_n <= 1'b0;
    repeat (8 + $unsigned($random(seed)) % 4) @(posedge ref_clk);
    chk(buf_ctl, cmp_pkg::BUF_RST);
    apb(1'b0, cmp_pkg::ADDR_STATUS, 32'h0);
    chk({q[9:8], q[6:5]}, 4'h2);
    pd_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk({buf_ctl.input_en, buf_ctl.output_en, buf_ctl.global_set_reset, buf_ctl.global_output_float}, 4'hC);
  endtask
  // One load in the mode set by c = {hi, lo, single}; brk cuts it with power-down
  task automatic load(input logic [2:0] c, input logic brk);
    cmp_pkg::cmp_mode_e m;
    m = exp_mode(c);
    apb(1'b1, cmp_pkg::ADDR_CTRL, {31'h0, c[0]});
    apb(1'b1, cmp_pkg::ADDR_LENGTH, len);
    m_hi <= c[2];
    m_lo <= c[1];
    prog_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    prog_n <= 1'b1;
    wait_cfg(cmp_pkg::CF_LOAD);
    chk(load_style, m);
    chk({pin_out.config_clock_oe_n, pin_out.high_while_loading_oe_n, pin_out.low_while_loading_oe_n,
      buf_ctl.mode_pullup_en}, {m != cmp_pkg::MODE_MASTER, 3'b001});
    if (brk) begin
      cmp_partner_inst.send(8, 1'b1);
      pd();
      wait_cfg(cmp_pkg::CF_LOAD);
      chk(q[7], 1'b0);
      apb(1'b0, cmp_pkg::ADDR_COUNT, 32'h0);
      chk(q, 32'h0);
    end
    if (m == cmp_pkg::MODE_SLAVE) begin
      cmp_partner_inst.send(8 * len, 1'b1);
    end else if (m == cmp_pkg::MODE_EXPRESS) begin
      cmp_partner_inst.send(2, 1'b0);
      cmp_partner_inst.send(len, 1'b1);
    end
    wait_cfg(cmp_pkg::CF_USER);
    chk(q[8:7], 2'b11);
    apb(1'b0, cmp_pkg::ADDR_COUNT, 32'h0);
    chk(q, len);
    chk({pin_out.high_while_loading_oe_n, pin_out.low_while_loading_oe_n, buf_ctl.mode_pullup_en}, 3'b110);
    m_hi <= ~c[2];
    m_lo <= ~c[1];
    repeat (6) @(posedge ref_clk);
    chk(load_style, m);
  endtask
  // --------------------
  // Main sequence
  // --------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pd_n = 1'b1;
    prog_n = 1'b1;
    m_hi = 1'b1;
    m_lo = 1'b1;
    repeat (12) @(posedge ref_clk);
    chk(buf_ctl, cmp_pkg::BUF_RST);
    chk(pin_out, cmp_pkg::PIN_RST);
    rst <= 1'b0;
    // Two link edges carry the reset release across before the first frame
    cmp_partner_inst.send(2, 1'b0);
    apb(1'b0, cmp_pkg::ADDR_LENGTH, 32'h0);
    chk(q, cmp_pkg::LENGTH_RST);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    chk({err, q[30:0]}, 32'h8000_0000);
    for (int i = 0; i < 8; i++) begin
      len = 1 + $unsigned($random(seed)) % 3;
      load(i[2:0], 1'b0);
    end
    len = 2 + $unsigned($random(seed)) % 2;
    load(3'b110, 1'b1);
    pd();
    apb(1'b0, cmp_pkg::ADDR_STATUS, 32'h0);
    chk(q[4:2], cmp_pkg::CF_USER);
    summarize();
  end
endmodule
